// ===== rtl/ers_read_seq.sv
// Operation
// - An internal byte address counter advances by one per byte read out.
// - START plus a read select byte is acknowledged by the device.
// - After a read select the counter's byte goes out MSB first, then +1; after a read cut off mid-byte the code sends the byte one above instead.
// - A master acknowledge on an output byte turns a read into a stream.
// - After a master acknowledge the next consecutive byte goes out.
// - Past the highest address the counter wraps to address zero.
// - After each output byte the data line is released for the ack bit.
// - A high data line in the ack bit ends the transfer into stand-by.
// - Single glitches of up to 100 ns on clock or data are ignored.
// - Only select bytes with type field 1010b are answered.
// - The chip-address bits must match the pins, else stand-by.
// - Two address bytes arrive MSB first; the top bit is ignored.
// - A write select and two address bytes load the counter for a read.
`timescale 1ns/1ps
module ers_read_seq
    import ers_pkg::*;
#(
    parameter int unsigned AW    = MEM_ADDR_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic          clock,
    input  wire logic          reset_n,
    input  wire logic          ce,
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe_n,
    input  wire logic          chip_addr_pin_lo,
    input  wire logic          chip_addr_pin_hi,
    input  wire logic          mem_wr_en,
    input  wire logic [AW-1:0] mem_wr_addr,
    input  wire logic [7:0]    mem_wr_data,
    output logic               standby,
    output logic               sel_match,
    output logic [AW-1:0]      addr_count
);

    // -----------------------------------------------------------------
    // Parameter checks.
    // -----------------------------------------------------------------
    // Two address bytes carry at most sixteen bits.
    if (AW < 1 || AW > 16) begin : g_bad_aw
        $error("ers_read_seq: AW must lie in 1..16");
    end

    // -----------------------------------------------------------------
    // State.
    // -----------------------------------------------------------------
    typedef struct packed {
        ers_state_e  fsm;
        logic [3:0]  bit_cnt;
        logic [7:0]  shreg;
        logic [7:0]  addr_hi;
        logic [AW-1:0] addr_cnt;
        logic [AW-1:0] fetch_ptr;
        logic        sda_oe_n;
        logic        scl_prev;
        logic        sda_prev;
        logic        ack_ok;
        logic        sel_match;
        logic [1:0]  pin_sync1;
        logic [1:0]  pin_sync2;
    } ers_seq_s;

    ers_seq_s q;
    ers_seq_s d;

    logic [7:0]    mem [2**AW];
    logic [1:0]    filt_in;
    logic [1:0]    filt_lvl;
    logic          scl_f;
    logic          sda_f;
    logic          load_evt;
    logic [AW-1:0] load_addr;
    logic          load_tx;
    logic          flush;
    logic          wr_ok;
    logic          push;
    logic          push_ready;
    logic          pop;
    logic          fifo_valid;
    logic [7:0]    fifo_data;
    logic          scl_rise;
    logic          scl_fall;
    logic          bus_start;
    logic          bus_stop;
    logic          byte_done;

    // Decodes a received select byte against type field and pins.
    function automatic logic sel_ok(input logic [7:0] b,
                                    input logic [1:0] pins);
        sel_ok = (b[7:SEL_TYPE_LSB] == DEV_TYPE_ID) &&
                 !b[SEL_ZERO_BIT] &&
                 (b[SEL_CE_HI_BIT] == pins[1]) &&
                 (b[SEL_CE_LO_BIT] == pins[0]);
    endfunction

    // -----------------------------------------------------------------
    // Input filtering of both bus lines.
    // -----------------------------------------------------------------
    assign filt_in = {sda_in, scl_in};

    for (genvar i = 0; i < 2; i++) begin : g_filt
        ers_glitch_filter #(
            .STABLE_CYC (GLITCH_CYC)
        ) u_filt (
            .clock   (clock),
            .reset_n (reset_n),
            .ce      (ce),
            .pin_in  (filt_in[i]),
            .level   (filt_lvl[i])
        );
    end

    assign scl_f = filt_lvl[0];
    assign sda_f = filt_lvl[1];

    // Bus events seen on the filtered levels.
    assign scl_rise  = scl_f && !q.scl_prev;
    assign scl_fall  = !scl_f && q.scl_prev;
    assign bus_start = scl_f && q.scl_prev && q.sda_prev && !sda_f;
    assign bus_stop  = scl_f && q.scl_prev && !q.sda_prev && sda_f;
    assign byte_done = scl_fall && (q.bit_cnt == BITS_PER_BYTE);

    // -----------------------------------------------------------------
    // Byte prefetch buffer.
    // -----------------------------------------------------------------
    // The fetcher runs ahead of the address counter; bytes leave only
    // when the shifter takes one, so the buffer fills and its ready
    // stalls the fetcher. A byte is popped when its shift starts but counted
    // only at its end, so a read cut off inside a byte leaves the buffer one ahead.
    ers_fifo #(
        .W     (BYTE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset_n   (reset_n),
        .ce        (ce),
        .flush     (flush),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (mem[q.fetch_ptr]),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // Array loads are only taken in stand-by, so a stream never sees a
    // buffer refilled under its feet.
    assign wr_ok = ce && mem_wr_en && (q.fsm == SEQ_IDLE);
    assign flush = load_evt || wr_ok;
    assign push  = ce && !flush;
    assign pop   = ce && load_tx;

    // Array write port.
    always_ff @(posedge clock) begin
        if (wr_ok) begin
            mem[mem_wr_addr] <= mem_wr_data;
        end
    end

    // -----------------------------------------------------------------
    // Sequencer.
    // -----------------------------------------------------------------
    // All data line changes happen on a filtered clock fall, so output
    // bits are stable across each high phase.
    always_comb begin
        d         = q;
        load_evt  = 1'b0;
        load_addr = q.addr_cnt;
        load_tx   = 1'b0;
        if (ce) begin
            d.sel_match = 1'b0;
            d.pin_sync1 = {chip_addr_pin_hi, chip_addr_pin_lo};
            d.pin_sync2 = q.pin_sync1;
            d.scl_prev  = scl_f;
            d.sda_prev  = sda_f;
            if (bus_stop) begin
                d.fsm      = SEQ_IDLE;
                d.sda_oe_n = SDA_RELEASED;
            end else if (bus_start) begin
                d.fsm      = SEQ_DEV;
                d.bit_cnt  = 4'h0;
                d.sda_oe_n = SDA_RELEASED;
            end else begin
                unique case (q.fsm)
                    SEQ_IDLE, SEQ_WAIT: begin
                        // Stand-by, or data bytes of a write, which are
                        // left unacknowledged.
                    end
                    SEQ_DEV, SEQ_AHI, SEQ_ALO: begin
                        if (scl_rise) begin
                            d.shreg   = {q.shreg[6:0], sda_f};
                            d.bit_cnt = q.bit_cnt + 4'h1;
                        end else if (byte_done) begin
                            d.bit_cnt  = 4'h0;
                            d.sda_oe_n = 1'b0;
                            if (q.fsm == SEQ_DEV) begin
                                if (sel_ok(q.shreg, q.pin_sync2)) begin
                                    d.sel_match = 1'b1;
                                    d.fsm = (q.shreg[SEL_RW_BIT] ==
                                             SEL_RW_READ) ?
                                            SEQ_DEV_ARD : SEQ_DEV_AWR;
                                end else begin
                                    d.sda_oe_n = SDA_RELEASED;
                                    d.fsm      = SEQ_IDLE;
                                end
                            end else if (q.fsm == SEQ_AHI) begin
                                d.addr_hi = q.shreg;
                                d.fsm     = SEQ_AHI_ACK;
                            end else begin
                                load_evt   = 1'b1;
                                load_addr  = AW'({q.addr_hi[6:0],
                                                  q.shreg});
                                d.addr_cnt = load_addr;
                                d.fsm      = SEQ_ALO_ACK;
                            end
                        end
                    end
                    SEQ_DEV_AWR, SEQ_AHI_ACK, SEQ_ALO_ACK: begin
                        if (scl_fall) begin
                            d.sda_oe_n = SDA_RELEASED;
                            d.fsm = (q.fsm == SEQ_DEV_AWR) ? SEQ_AHI :
                                    (q.fsm == SEQ_AHI_ACK) ? SEQ_ALO :
                                                             SEQ_WAIT;
                        end
                    end
                    SEQ_DEV_ARD: begin
                        if (scl_fall) begin
                            load_tx = 1'b1;
                        end
                    end
                    SEQ_TX: begin
                        if (byte_done) begin
                            d.sda_oe_n = SDA_RELEASED;
                            d.addr_cnt = q.addr_cnt + 1'b1;
                            d.fsm      = SEQ_TX_ACK;
                        end else if (scl_fall) begin
                            d.shreg    = {q.shreg[6:0], 1'b0};
                            d.sda_oe_n = q.shreg[6];
                            d.bit_cnt  = q.bit_cnt + 4'h1;
                        end
                    end
                    SEQ_TX_ACK: begin
                        if (scl_rise) begin
                            d.ack_ok = !sda_f;
                        end else if (scl_fall) begin
                            if (q.ack_ok) begin
                                load_tx = 1'b1;
                            end else begin
                                d.fsm = SEQ_IDLE;
                            end
                        end
                    end
                    default: begin
                        d.sda_oe_n = SDA_RELEASED;
                        d.fsm      = SEQ_IDLE;
                    end
                endcase
            end

            // Start shifting a byte: MSB goes out at once.
            if (load_tx) begin
                d.shreg    = fifo_data;
                d.sda_oe_n = fifo_data[7];
                d.bit_cnt  = 4'h1;
                d.fsm      = SEQ_TX;
            end

            // The fetcher restarts at the counter after any flush; the
            // flush terms are read directly so no net loops back here.
            if (load_evt || wr_ok) begin
                d.fetch_ptr = load_addr;
            end else if (push_ready) begin
                d.fetch_ptr = q.fetch_ptr + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q           <= '0;
            q.fsm       <= SEQ_IDLE;
            q.sda_oe_n  <= SDA_RELEASED;
            q.scl_prev  <= BUS_IDLE_LEVEL;
            q.sda_prev  <= BUS_IDLE_LEVEL;
        end else begin
            q <= d;
        end
    end

    // -----------------------------------------------------------------
    // Outputs.
    // -----------------------------------------------------------------
    // Open drain: the pad only ever pulls low.
    assign sda_out    = 1'b0;
    assign sda_oe_n   = q.sda_oe_n;
    assign standby    = (q.fsm == SEQ_IDLE);
    assign sel_match  = q.sel_match;
    assign addr_count = q.addr_cnt;

endmodule

// ===== shared/ers_pkg.sv
// ---------------------------------------------------------------------
// Shared constants of the serial EEPROM read sequencer.
// ---------------------------------------------------------------------
package ers_pkg;

    // -----------------------------------------------------------------
    // Timing.
    // -----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned GLITCH_NS     = 100;
    // A glitch as wide as the limit can cover one sample more than its
    // width in whole periods, so the level waits one sample beyond that.
    localparam int unsigned GLITCH_CYC    =
        GLITCH_NS / CLK_PERIOD_NS + 2;

    // -----------------------------------------------------------------
    // Array and buffer geometry.
    // -----------------------------------------------------------------
    localparam int unsigned MEM_ADDR_W = 15;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned FIFO_DEPTH = 8;

    // -----------------------------------------------------------------
    // Select byte layout.
    // -----------------------------------------------------------------
    localparam logic [3:0]  DEV_TYPE_ID   = 4'ha;
    localparam int unsigned SEL_TYPE_LSB  = 4;
    localparam int unsigned SEL_ZERO_BIT  = 3;
    localparam int unsigned SEL_CE_HI_BIT = 2;
    localparam int unsigned SEL_CE_LO_BIT = 1;
    localparam int unsigned SEL_RW_BIT    = 0;
    localparam logic        SEL_RW_READ   = 1'b1;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

    // -----------------------------------------------------------------
    // Reset values.
    // -----------------------------------------------------------------
    localparam logic BUS_IDLE_LEVEL = 1'b1;
    localparam logic SDA_RELEASED   = 1'b1;

    // -----------------------------------------------------------------
    // Sequencer states.
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        SEQ_IDLE    = 4'h0,
        SEQ_DEV     = 4'h1,
        SEQ_DEV_AWR = 4'h2,
        SEQ_DEV_ARD = 4'h3,
        SEQ_AHI     = 4'h4,
        SEQ_AHI_ACK = 4'h5,
        SEQ_ALO     = 4'h6,
        SEQ_ALO_ACK = 4'h7,
        SEQ_WAIT    = 4'h8,
        SEQ_TX      = 4'h9,
        SEQ_TX_ACK  = 4'ha
    } ers_state_e;

endpackage

// ===== rtl/ers_glitch_filter.sv
`timescale 1ns/1ps
module ers_glitch_filter
    import ers_pkg::*;
#(
    parameter int unsigned STABLE_CYC = GLITCH_CYC
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic pin_in,
    output logic      level
);

    // -----------------------------------------------------------------
    // The counter is eight bits wide, which bounds the stable count.
    // -----------------------------------------------------------------
    if (STABLE_CYC < 1 || STABLE_CYC > 255) begin : g_bad_cyc
        $error("ers_glitch_filter: STABLE_CYC out of range");
    end

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic [7:0] cnt;
        logic       lvl;
    } ers_filt_s;

    ers_filt_s q;
    ers_filt_s d;

    // Two flops bring the pin in, then the level only follows an input
    // that has held its new value for the full count, so shorter
    // pulses never reach the sequencer.
    always_comb begin
        d = q;
        if (ce) begin
            d.sync1 = pin_in;
            d.sync2 = q.sync1;
            if (q.sync2 == q.lvl) begin
                d.cnt = 8'h00;
            end else if (q.cnt == 8'(STABLE_CYC - 1)) begin
                d.lvl = q.sync2;
                d.cnt = 8'h00;
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end
    end

    // State register.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{sync1: BUS_IDLE_LEVEL, sync2: BUS_IDLE_LEVEL,
                   cnt: 8'h00, lvl: BUS_IDLE_LEVEL};
        end else begin
            q <= d;
        end
    end

    assign level = q.lvl;

endmodule

// ===== rtl/ers_fifo.sv
`timescale 1ns/1ps
module ers_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         ce,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    localparam int unsigned PW = $clog2(DEPTH);

    // -----------------------------------------------------------------
    // Pointers wrap naturally, so the depth must be a power of two.
    // -----------------------------------------------------------------
    if (DEPTH < 2 || (1 << PW) != DEPTH || W < 1) begin : g_bad_geom
        $error("ers_fifo: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW:0]             wp;
        logic [PW:0]             rp;
    } ers_fifo_s;

    ers_fifo_s q;
    ers_fifo_s d;

    // Full when the pointers differ only in the wrap bit.
    assign in_ready  = !((q.wp[PW] != q.rp[PW]) &&
                         (q.wp[PW-1:0] == q.rp[PW-1:0]));
    assign out_valid = (q.wp != q.rp);
    assign out_data  = q.mem[q.rp[PW-1:0]];

    // Flush drops everything; a push or pop in that cycle is lost.
    always_comb begin
        d = q;
        if (ce) begin
            if (flush) begin
                d.wp = '0;
                d.rp = '0;
            end else begin
                if (in_valid && in_ready) begin
                    d.mem[q.wp[PW-1:0]] = in_data;
                    d.wp = q.wp + 1'b1;
                end
                if (out_valid && out_ready) begin
                    d.rp = q.rp + 1'b1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// ===== sim/ers_read_seq_sva.sv
`timescale 1ns/1ps
module ers_read_seq_sva
    import ers_pkg::*;
#(
    parameter int unsigned AW = MEM_ADDR_W
) (
    input wire logic          clock,
    input wire logic          reset_n,
    input wire logic          ce,
    input wire logic          scl_in,
    input wire logic          sda_in,
    input wire logic          sda_out,
    input wire logic          sda_oe_n,
    input wire logic          chip_addr_pin_lo,
    input wire logic          chip_addr_pin_hi,
    input wire logic          mem_wr_en,
    input wire logic [AW-1:0] mem_wr_addr,
    input wire logic [7:0]    mem_wr_data,
    input wire logic          standby,
    input wire logic          sel_match,
    input wire logic [AW-1:0] addr_count
);
    // -----------------------------------------------------------------
    // Bus-side relations, all in the system clock domain.
    // -----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // The ack must outlast the filter delay of about 16 cycles; this checks only the first eight.
    sequence s_ack_held;
        !sda_oe_n [*8];
    endsequence
    sequence s_idle_twice;
        standby && $past(standby);
    endsequence

    a_out_zero: assert property (sda_out == 1'b0)
        else $error("data value not zero");
    a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data line moved while clock high");
    a_sel_pulse: assert property (sel_match |=> !sel_match)
        else $error("select pulse too long");
    a_sel_busy: assert property (sel_match |-> !standby)
        else $error("select acked in stand-by");
    a_sel_ack_held: assert property (sel_match |-> s_ack_held)
        else $error("select ack not held");
    a_idle_release: assert property (s_idle_twice |-> sda_oe_n)
        else $error("data driven in stand-by");
    a_idle_count: assert property (
        s_idle_twice |-> $stable(addr_count))
        else $error("counter moved in stand-by");
    // A counter load takes the line for the address ack at that edge,
    // so a load that happens to land one above is not a step.
    a_count_release: assert property ($changed(addr_count) &&
        !$fell(sda_oe_n) && addr_count == $past(addr_count) + 1'b1
        |-> sda_oe_n)
        else $error("counter stepped while driving");
endmodule

bind ers_read_seq ers_read_seq_sva #(.AW(AW)) u_sva (
    .clock(clock), .reset_n(reset_n), .ce(ce), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .chip_addr_pin_lo(chip_addr_pin_lo),
    .chip_addr_pin_hi(chip_addr_pin_hi), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .standby(standby), .sel_match(sel_match), .addr_count(addr_count)
);

// ===== sim/ers_bus_master.sv
`timescale 1ns/1ps
module ers_bus_master #(
    parameter int unsigned QUARTER_NS = 496
) (
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda_w
);
    // -----------------------------------------------------------------
    // Behavioural master; SCL stands high outside frames. The quarter
    // is a whole number of clock periods, so called from a falling
    // clock edge every bus change stays clear of the sampling edge.
    // -----------------------------------------------------------------
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end

    // Also serves as repeated START, since it starts from SCL low.
    task bm_start;
        sda_rel = 1'b1;
        #QUARTER_NS scl = 1'b1;
        #QUARTER_NS sda_rel = 1'b0;
        #QUARTER_NS scl = 1'b0;
    endtask

    task bm_stop;
        sda_rel = 1'b0;
        #QUARTER_NS scl = 1'b1;
        #QUARTER_NS sda_rel = 1'b1;
        #QUARTER_NS;
    endtask

    // Data changes mid-low and is sampled mid-high, well past the filter.
    task bm_bit(input logic b, output logic r);
        #QUARTER_NS sda_rel = b;
        #QUARTER_NS scl = 1'b1;
        #QUARTER_NS r = sda_w;
        #QUARTER_NS scl = 1'b0;
    endtask

    task bm_wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bm_bit(d[i], r);
        end
        bm_bit(1'b1, ack);
    endtask

    // A high mack withholds the acknowledge and ends the stream.
    task bm_rd(input logic mack, output logic [7:0] d, output logic seen);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bm_bit(1'b1, r);
            d = {d[6:0], r};
        end
        bm_bit(mack, seen);
    endtask

    // A short low pulse on SDA while SCL is high mimics a false START.
    task bm_glitch(input int unsigned len);
        sda_rel = 1'b0;
        #len sda_rel = 1'b1;
        #QUARTER_NS scl = 1'b0;
    endtask
endmodule

// ===== sim/eeprom_read_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    n_errors++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module eeprom_read_sequencer_tb_top;
    import ers_pkg::*;
    logic                  clock;
    logic                  reset_n;
    logic                  ce;
    logic                  pin_lo;
    logic                  pin_hi;
    logic                  wr_en;
    logic [MEM_ADDR_W-1:0] wr_addr;
    logic [7:0]            wr_data;
    logic                  sda_out;
    logic                  sda_oe_n;
    logic                  standby;
    logic                  sel_match;
    logic [MEM_ADDR_W-1:0] addr_count;
    logic                  scl;
    logic                  sda_rel;
    wire                   sda_w;
    int                    n_errors;
    int                    n_compared;

    // Pulled-up wire: low when either party pulls it.
    assign sda_w = sda_rel & (sda_oe_n | sda_out);

    ers_read_seq #(.AW(MEM_ADDR_W), .DEPTH(FIFO_DEPTH)) uut (
        .clock(clock), .reset_n(reset_n), .ce(ce), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .chip_addr_pin_lo(pin_lo), .chip_addr_pin_hi(pin_hi),
        .mem_wr_en(wr_en), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data),
        .standby(standby), .sel_match(sel_match), .addr_count(addr_count)
    );
    ers_bus_master #(.QUARTER_NS(496)) bm (
        .scl(scl), .sda_rel(sda_rel), .sda_w(sda_w)
    );

    // -----------------------------------------------------------------
    // Helpers.
    // -----------------------------------------------------------------
    function automatic logic [7:0] ex_byte(input logic [14:0] a);
        return {a[3:0], ~a[3:0]};
    endfunction

    task finish_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Back-to-back preload, including both ends of the array.
    task t_preload;
        logic [14:0] pa [6];
        pa = '{15'h7ffe, 15'h7fff, 15'h0000, 15'h0001, 15'h0002, 15'h0003};
        for (int k = 0; k < 6; k++) begin
            @(negedge clock);
            wr_en   = 1'b1;
            wr_addr = pa[k];
            wr_data = ex_byte(pa[k]);
        end
        @(negedge clock);
        wr_en = 1'b0;
    endtask

    // Random read with bit 15 set, then a stream across the wrap.
    task t_random_seq;
        logic        ack;
        logic        seen;
        logic [7:0]  d;
        logic [14:0] a;
        a = 15'h7ffe;
        bm.bm_start;
        bm.bm_wr(8'ha2, ack);
        `CHK("sel_wr_ack", 1'b0, ack)
        bm.bm_wr(8'hff, ack);
        `CHK("addr_hi_ack", 1'b0, ack)
        bm.bm_wr(8'hfe, ack);
        `CHK("addr_lo_ack", 1'b0, ack)
        bm.bm_start;
        bm.bm_wr(8'ha3, ack);
        `CHK("sel_rd_ack", 1'b0, ack)
        for (int k = 0; k < 4; k++) begin
            bm.bm_rd(k == 3, d, seen);
            `CHK("seq_byte", ex_byte(a), d)
            a = a + 15'h0001;
        end
        `CHK("nack_released", 1'b1, seen)
        repeat (40) @(negedge clock);
        `CHK("nack_standby", 1'b1, standby)
        `CHK("wrap_count", 15'h0002, addr_count)
        bm.bm_stop;
    endtask

    // Single-byte current-address read.
    task t_current;
        logic       ack;
        logic       seen;
        logic [7:0] d;
        bm.bm_start;
        bm.bm_wr(8'ha3, ack);
        `CHK("cur_ack", 1'b0, ack)
        bm.bm_rd(1'b1, d, seen);
        `CHK("cur_byte", ex_byte(15'h0002), d)
        `CHK("cur_released", 1'b1, seen)
        bm.bm_stop;
        repeat (40) @(negedge clock);
        `CHK("cur_count", 15'h0003, addr_count)
    endtask

    // Wrong type, bit 3 set, wrong chip bits; then moved pins.
    task t_refuse;
        logic       ack;
        logic       seen;
        logic [7:0] d;
        logic [7:0] bad [4];
        bad = '{8'hb3, 8'hab, 8'ha5, 8'ha1};
        for (int k = 0; k < 4; k++) begin
            bm.bm_start;
            bm.bm_wr(bad[k], ack);
            `CHK("bad_sel_ack", 1'b1, ack)
            repeat (40) @(negedge clock);
            `CHK("bad_sel_standby", 1'b1, standby)
            bm.bm_stop;
        end
        @(negedge clock);
        pin_lo = 1'b0;
        pin_hi = 1'b1;
        repeat (10) @(negedge clock);
        bm.bm_start;
        bm.bm_wr(8'ha5, ack);
        `CHK("pin_sel_ack", 1'b0, ack)
        bm.bm_rd(1'b1, d, seen);
        `CHK("pin_byte", ex_byte(15'h0003), d)
        bm.bm_stop;
        @(negedge clock);
        pin_lo = 1'b1;
        pin_hi = 1'b0;
    endtask

    // A filtered-out START must leave the device deaf to the byte.
    task t_glitch;
        logic ack;
        bm.bm_glitch(96);
        bm.bm_wr(8'ha3, ack);
        `CHK("glitch_ack", 1'b1, ack)
        `CHK("glitch_standby", 1'b1, standby)
        bm.bm_stop;
    endtask

    // -----------------------------------------------------------------
    // Clock, main sequence and watchdog.
    // -----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        n_errors   = 0;
        n_compared = 0;
        reset_n    = 1'b0;
        ce         = 1'b1;
        pin_lo     = 1'b1;
        pin_hi     = 1'b0;
        wr_en      = 1'b0;
        wr_addr    = '0;
        wr_data    = '0;
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        repeat (30) @(negedge clock);
        t_preload;
        t_random_seq;
        t_current;
        t_refuse;
        t_glitch;
        finish_test;
    end

    // The sequence needs about 330 us of bus time.
    initial begin
        #700000;
        n_errors++;
        finish_test;
    end
endmodule
